// ==== hw/iofs_top.sv ====
// Added by the designer: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
// What this block does
// - external modes: clock-in drives system, clock-out selectable
// - internal clock_out_pin mode: clock-out is freq/4
// - internal io mode: both pins are gpio
// - postscaler divides by 1, 2, 4 or 8
// - locked source set: 16/8/4/2 MHz
// - locked source clear: 500/250/125/62.5 kHz
// - every reset loads frequency select with 10
// - locked source fixed, software cannot change
// - new frequency code applies without delay
// - bit 3 reads oscillator locked within 2%
// - bit 2 reads oscillator at best accuracy
// - bits 7-6, 1-0 read zero, ignore writes
// - six-bit signed tuning, resets to zero
module iofs_top
  import iofs_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic [1:0]  clock_mode_cfg,
  input  wire logic        locked_source_cfg,
  input  wire logic        high_freq_internal_source,
  input  wire logic        mid_freq_internal_source,
  input  wire logic        osc_locked_raw,
  input  wire logic        osc_stable_raw,
  input  wire logic        clock_in_pin_i,
  input  wire logic        clock_in_gpio_o,
  input  wire logic        clock_in_gpio_oe_n,
  output logic             clock_in_pin_o,
  output logic             clock_in_pin_oe_n,
  input  wire logic        clock_out_pin_i,
  input  wire logic        clock_out_gpio_o,
  input  wire logic        clock_out_gpio_oe_n,
  output logic             clock_out_pin_o,
  output logic             clock_out_pin_oe_n,
  output logic             sys_clk_o,
  output logic             int_clk_o,
  output logic [5:0]       osc_tuning_o,
  output logic             irq
);

  // ************************************************************
  // status synchronisers
  // ************************************************************
  iofs_sync_if lock_if ();
  iofs_sync_if stab_if ();
  assign lock_if.raw = osc_locked_raw;
  assign stab_if.raw = osc_stable_raw;

  iofs_sync u_lock_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .s       (lock_if.dst)
  );

  iofs_sync u_stab_sync
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .s       (stab_if.dst)
  );

  logic locked_s;
  logic stable_s;
  assign locked_s = lock_if.synced;
  assign stable_s = stab_if.synced;

  // ************************************************************
  // register state
  // ************************************************************
  logic [1:0]          freq_sel_reg;
  logic [1:0]          freq_sel_next;
  logic [5:0]          tuning_reg;
  logic [5:0]          tuning_next;
  logic [IRQ_W-1:0]    irq_stat_reg;
  logic [IRQ_W-1:0]    irq_stat_next;
  logic [IRQ_W-1:0]    irq_mask_reg;
  logic [IRQ_W-1:0]    irq_mask_next;
  logic                locked_d_reg;
  logic                stable_d_reg;
  logic                irq_reg;
  logic                irq_next;

  // ************************************************************
  // axi write channel
  // ************************************************************
  logic        aw_have_reg;
  logic        aw_have_next;
  logic [11:0] aw_addr_reg;
  logic [11:0] aw_addr_next;
  logic        w_have_reg;
  logic        w_have_next;
  logic [31:0] w_data_reg;
  logic [31:0] w_data_next;
  logic        w_strb0_reg;
  logic        w_strb0_next;
  logic        bvalid_reg;
  logic        bvalid_next;
  logic [1:0]  bresp_reg;
  logic [1:0]  bresp_next;
  logic        do_write;

  assign do_write = aw_have_reg && w_have_reg && !bvalid_reg;

  always_comb
  begin
    aw_have_next = aw_have_reg;
    aw_addr_next = aw_addr_reg;
    w_have_next  = w_have_reg;
    w_data_next  = w_data_reg;
    w_strb0_next = w_strb0_reg;
    bvalid_next  = bvalid_reg;
    bresp_next   = bresp_reg;
    if (s_axi_awvalid && !aw_have_reg)
    begin
      aw_have_next = 1'b1;
      aw_addr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_have_reg)
    begin
      w_have_next  = 1'b1;
      w_data_next  = s_axi_wdata;
      w_strb0_next = s_axi_wstrb[0];
    end
    if (do_write)
    begin
      aw_have_next = 1'b0;
      w_have_next  = 1'b0;
      bvalid_next  = 1'b1;
      case (aw_addr_reg)
        IOFS_OSC_CONTROL_OFS,
        IOFS_OSC_TUNING_OFS,
        IOFS_IRQ_STATUS_OFS,
        IOFS_IRQ_MASK_OFS: bresp_next = AXI_OKAY;
        default:           bresp_next = AXI_SLVERR;
      endcase
    end
    else if (bvalid_reg && s_axi_bready)
    begin
      bvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_have_reg  <= 1'b0;
      w_data_reg  <= 32'h0000_0000;
      w_strb0_reg <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= AXI_OKAY;
    end
    else
    begin
      aw_have_reg <= aw_have_next;
      aw_addr_reg <= aw_addr_next;
      w_have_reg  <= w_have_next;
      w_data_reg  <= w_data_next;
      w_strb0_reg <= w_strb0_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
    end
  end

  // ************************************************************
  // control and interrupt registers
  // ************************************************************
  logic            wr_lane;
  logic [IRQ_W-1:0] irq_events;
  assign wr_lane    = do_write && w_strb0_reg;
  assign irq_events = {stable_s & ~stable_d_reg, locked_s & ~locked_d_reg};

  always_comb
  begin
    freq_sel_next = freq_sel_reg;
    tuning_next   = tuning_reg;
    irq_mask_next = irq_mask_reg;
    irq_stat_next = irq_stat_reg;
    if (wr_lane)
    begin
      case (aw_addr_reg)
        // only the field bits are stored; others dropped
        IOFS_OSC_CONTROL_OFS:
          freq_sel_next = w_data_reg[FREQ_SEL_MSB:FREQ_SEL_LSB];
        IOFS_OSC_TUNING_OFS:
          tuning_next = w_data_reg[TUNING_W-1:0];
        IOFS_IRQ_MASK_OFS:
          irq_mask_next = w_data_reg[IRQ_W-1:0];
        IOFS_IRQ_STATUS_OFS:
          irq_stat_next = irq_stat_reg & ~w_data_reg[IRQ_W-1:0];
        default:
          freq_sel_next = freq_sel_reg;
      endcase
    end
    // set beats a simultaneous clear
    irq_stat_next = irq_stat_next | irq_events;
    irq_next      = |(irq_stat_next & irq_mask_next);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      freq_sel_reg <= FREQ_SEL_RESET;
      tuning_reg   <= TUNING_RESET;
      irq_mask_reg <= '0;
      irq_stat_reg <= '0;
      locked_d_reg <= 1'b0;
      stable_d_reg <= 1'b0;
      irq_reg      <= 1'b0;
    end
    else
    begin
      freq_sel_reg <= freq_sel_next;
      tuning_reg   <= tuning_next;
      irq_mask_reg <= irq_mask_next;
      irq_stat_reg <= irq_stat_next;
      locked_d_reg <= locked_s;
      stable_d_reg <= stable_s;
      irq_reg      <= irq_next;
    end
  end

  // ************************************************************
  // axi read channel
  // ************************************************************
  logic        rvalid_reg;
  logic        rvalid_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [1:0]  rresp_reg;
  logic [1:0]  rresp_next;
  logic [7:0]  ctrl_view;

  always_comb
  begin
    ctrl_view = 8'h00;
    ctrl_view[FREQ_SEL_MSB:FREQ_SEL_LSB] = freq_sel_reg;
    ctrl_view[LOCKED_BIT] = locked_s;
    ctrl_view[STABLE_BIT] = stable_s;
  end

  always_comb
  begin
    rvalid_next = rvalid_reg;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (s_axi_arvalid && !rvalid_reg)
    begin
      rvalid_next = 1'b1;
      rresp_next  = AXI_OKAY;
      case (s_axi_araddr)
        IOFS_OSC_CONTROL_OFS: rdata_next = {24'h00_0000, ctrl_view};
        IOFS_OSC_TUNING_OFS:  rdata_next = {26'h000_0000, tuning_reg};
        IOFS_IRQ_STATUS_OFS:  rdata_next = {30'h0000_0000, irq_stat_reg};
        IOFS_IRQ_MASK_OFS:    rdata_next = {30'h0000_0000, irq_mask_reg};
        default:
        begin
          rdata_next = 32'h0000_0000;
          rresp_next = AXI_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_next = 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= AXI_OKAY;
    end
    else
    begin
      rvalid_reg <= rvalid_next;
      rdata_reg  <= rdata_next;
      rresp_reg  <= rresp_next;
    end
  end

  // ************************************************************
  // postscaler and clock-out divider
  // ************************************************************
  // locked_source_cfg is a strap input with no software path
  logic              src_clk;
  logic [POST_W-1:0] post_cnt_reg;
  logic [POST_W-1:0] post_cnt_next;
  logic              src_d_reg;
  logic              int_clk_next;
  logic              int_clk_reg;
  logic              int_d_reg;
  logic [1:0]        co_cnt_reg;
  logic [1:0]        co_cnt_next;

  // source clocks are sampled as plain inputs; internal clocks are
  // derived by edge counting, so rates must stay below aclk/2
  assign src_clk = locked_source_cfg ? high_freq_internal_source
                                     : mid_freq_internal_source;

  always_comb
  begin
    post_cnt_next = post_cnt_reg;
    if (src_clk && !src_d_reg)
    begin
      post_cnt_next = post_cnt_reg + 4'h1;
    end
    // code 11 divides by 1, 10 by 2, 01 by 4, 00 by 8
    case (freq_sel_reg)
      2'h3:    int_clk_next = src_clk;
      2'h2:    int_clk_next = post_cnt_reg[0];
      2'h1:    int_clk_next = post_cnt_reg[1];
      default: int_clk_next = post_cnt_reg[2];
    endcase
    // mux picks up new code on the next edge: no restart
    co_cnt_next = co_cnt_reg;
    if (int_clk_reg && !int_d_reg)
    begin
      co_cnt_next = co_cnt_reg + 2'h1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      post_cnt_reg <= '0;
      src_d_reg    <= 1'b0;
      int_clk_reg  <= 1'b0;
      int_d_reg    <= 1'b0;
      co_cnt_reg   <= 2'h0;
    end
    else
    begin
      post_cnt_reg <= post_cnt_next;
      src_d_reg    <= src_clk;
      int_clk_reg  <= int_clk_next;
      int_d_reg    <= int_clk_reg;
      co_cnt_reg   <= co_cnt_next;
    end
  end

  // ************************************************************
  // pin roles and system clock selection
  // ************************************************************
  iofs_mode_e mode;
  logic       sys_next;
  logic       ci_o_next;
  logic       ci_oe_n_next;
  logic       co_o_next;
  logic       co_oe_n_next;
  logic       sys_reg;
  logic       ci_o_reg;
  logic       ci_oe_n_reg;
  logic       co_o_reg;
  logic       co_oe_n_reg;

  assign mode = iofs_mode_e'(clock_mode_cfg);

  always_comb
  begin
    sys_next     = int_clk_reg;
    ci_o_next    = clock_in_gpio_o;
    ci_oe_n_next = clock_in_gpio_oe_n;
    co_o_next    = clock_out_gpio_o;
    co_oe_n_next = clock_out_gpio_oe_n;
    case (mode)
      IOFS_EXT_CLOCK_OUT_PIN:
      begin
        sys_next     = clock_in_pin_i;
        ci_o_next    = 1'b0;
        ci_oe_n_next = 1'b1;
        co_o_next    = clock_in_pin_i;
        co_oe_n_next = 1'b0;
      end
      IOFS_EXT_IO:
      begin
        sys_next     = clock_in_pin_i;
        ci_o_next    = 1'b0;
        ci_oe_n_next = 1'b1;
      end
      IOFS_INT_CLOCK_OUT_PIN:
      begin
        co_o_next    = co_cnt_reg[CLOCK_OUT_PIN_DIV_LOG2-1];
        co_oe_n_next = 1'b0;
      end
      IOFS_INT_IO:
      begin
        sys_next = int_clk_reg;
      end
      default:
      begin
        sys_next = int_clk_reg;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sys_reg     <= 1'b0;
      ci_o_reg    <= 1'b0;
      ci_oe_n_reg <= 1'b1;
      co_o_reg    <= 1'b0;
      co_oe_n_reg <= 1'b1;
    end
    else
    begin
      sys_reg     <= sys_next;
      ci_o_reg    <= ci_o_next;
      ci_oe_n_reg <= ci_oe_n_next;
      co_o_reg    <= co_o_next;
      co_oe_n_reg <= co_oe_n_next;
    end
  end

  assign s_axi_awready      = !aw_have_reg;
  assign s_axi_wready       = !w_have_reg;
  assign s_axi_bvalid       = bvalid_reg;
  assign s_axi_bresp        = bresp_reg;
  assign s_axi_arready      = !rvalid_reg;
  assign s_axi_rvalid       = rvalid_reg;
  assign s_axi_rdata        = rdata_reg;
  assign s_axi_rresp        = rresp_reg;
  assign clock_in_pin_o     = ci_o_reg;
  assign clock_in_pin_oe_n  = ci_oe_n_reg;
  assign clock_out_pin_o    = co_o_reg;
  assign clock_out_pin_oe_n = co_oe_n_reg;
  assign sys_clk_o          = sys_reg;
  assign int_clk_o          = int_clk_reg;
  assign osc_tuning_o       = tuning_reg;
  assign irq                = irq_reg;

endmodule // iofs_top

// ==== hw/iofs_pkg.sv ====
package iofs_pkg;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [11:0] IOFS_OSC_CONTROL_OFS = 12'h000;
  localparam logic [11:0] IOFS_OSC_TUNING_OFS  = 12'h004;
  localparam logic [11:0] IOFS_IRQ_STATUS_OFS  = 12'h008;
  localparam logic [11:0] IOFS_IRQ_MASK_OFS    = 12'h00C;

  // ************************************************************
  // oscillator control fields
  // ************************************************************
  localparam int FREQ_SEL_LSB   = 4;
  localparam int FREQ_SEL_MSB   = 5;
  localparam int LOCKED_BIT     = 3;
  localparam int STABLE_BIT     = 2;
  localparam logic [1:0] FREQ_SEL_RESET = 2'h2;
  localparam logic [5:0] TUNING_RESET   = 6'h00;
  localparam int TUNING_W       = 6;

  // interrupt status bit positions
  localparam int IRQ_LOCK_BIT   = 0;
  localparam int IRQ_STABLE_BIT = 1;
  localparam int IRQ_W          = 2;

  // ************************************************************
  // clock mode configuration encodings
  // ************************************************************
  typedef enum logic [1:0] {
    IOFS_EXT_CLOCK_OUT_PIN = 2'h0,
    IOFS_EXT_IO     = 2'h1,
    IOFS_INT_CLOCK_OUT_PIN = 2'h2,
    IOFS_INT_IO     = 2'h3
  } iofs_mode_e;

  // clock-out divides selected internal frequency by four
  localparam int CLOCK_OUT_PIN_DIV_LOG2 = 2;
  localparam int POST_W          = 4;

  // AXI responses
  localparam logic [1:0] AXI_OKAY   = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;

endpackage

// ==== hw/iofs_sync_if.sv ====
`timescale 1ns/100ps
interface iofs_sync_if;
  logic raw;
  logic synced;
  modport src (output raw, input synced);
  modport dst (input raw, output synced);
endinterface

// ==== hw/iofs_sync.sv ====
`timescale 1ns/100ps
module iofs_sync
(
  input  wire logic aclk,
  input  wire logic aresetn,
  iofs_sync_if.dst  s
);
  logic meta_reg;
  logic meta_next;
  logic out_reg;
  logic out_next;

  always_comb
  begin
    meta_next = s.raw;
    out_next  = meta_reg;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      meta_reg <= 1'b0;
      out_reg  <= 1'b0;
    end
    else
    begin
      meta_reg <= meta_next;
      out_reg  <= out_next;
    end
  end

  assign s.synced = out_reg;
endmodule // iofs_sync

// ==== dv/iofs_osc_model.sv ====
`timescale 1ns/100ps
// ************************************************************
// internal sources, external clock, analog status
// ************************************************************
module iofs_osc_model
#(
  parameter int LOCK_NS   = 1000,
  parameter int STABLE_NS = 2000
)
(
  output logic hf_src,
  output logic mf_src,
  output logic ext_clk,
  output logic locked_raw,
  output logic stable_raw
);
  // 2 ns ahead of the rising bus clock edges, so every sample is clean
  initial
  begin
    hf_src     = 1'b0;
    mf_src     = 1'b0;
    ext_clk    = 1'b0;
    locked_raw = 1'b0;
    stable_raw = 1'b0;
    #3;
    fork
      forever #20 hf_src = ~hf_src;
      forever #50 mf_src = ~mf_src;
      forever #30 ext_clk = ~ext_clk;
      #(LOCK_NS) locked_raw = 1'b1;
      #(STABLE_NS) stable_raw = 1'b1;
    join
  end
endmodule // iofs_osc_model

// ==== dv/iofs_top_assertions.sv ====
`timescale 1ns/100ps
// ************************************************************
// bus handshake and pin role checks
// ************************************************************
module iofs_top_assertions
  import iofs_pkg::*;
(
  input logic        aclk,
  input logic        aresetn,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic [1:0]  clock_mode_cfg,
  input logic        clock_in_pin_i,
  input logic        clock_in_gpio_oe_n,
  input logic        clock_in_pin_oe_n,
  input logic        clock_out_gpio_o,
  input logic        clock_out_gpio_oe_n,
  input logic        clock_out_pin_o,
  input logic        clock_out_pin_oe_n,
  input logic        sys_clk_o,
  input logic [5:0]  osc_tuning_o
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  write_lat_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  ext_sysclk_a:
    assert property (aresetn && !clock_mode_cfg[1] |=> clock_in_pin_oe_n &&
      sys_clk_o == $past(clock_in_pin_i)) else $error("ext clock lost");
  ext_clock_out_pin_a:
    assert property (aresetn && clock_mode_cfg == IOFS_EXT_CLOCK_OUT_PIN |=>
      !clock_out_pin_oe_n && clock_out_pin_o == $past(clock_in_pin_i))
    else $error("ext clock-out wrong");
  int_clock_out_pin_a:
    assert property (aresetn && clock_mode_cfg == IOFS_INT_CLOCK_OUT_PIN |=>
      !clock_out_pin_oe_n && clock_in_pin_oe_n == $past(clock_in_gpio_oe_n))
    else $error("int clock-out pins wrong");
  io_mode_a:
    assert property (aresetn && clock_mode_cfg == IOFS_INT_IO |=>
      clock_out_pin_oe_n == $past(clock_out_gpio_oe_n) &&
      clock_out_pin_o == $past(clock_out_gpio_o) &&
      clock_in_pin_oe_n == $past(clock_in_gpio_oe_n))
    else $error("io mode pins wrong");
  tuning_write_a:
    assert property (aresetn && $changed(osc_tuning_o) |->
      $rose(s_axi_bvalid))
    else $error("tuning moved without write");
endmodule // iofs_top_assertions

bind iofs_top iofs_top_assertions chk_u (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rvalid, .s_axi_rready, .clock_mode_cfg, .clock_in_pin_i,
  .clock_in_gpio_oe_n, .clock_in_pin_oe_n, .clock_out_gpio_o,
  .clock_out_gpio_oe_n, .clock_out_pin_o, .clock_out_pin_oe_n, .sys_clk_o,
  .osc_tuning_o);

// ==== dv/tb.sv ====
`timescale 1ns/100ps
// ************************************************************
// register, frequency and pin role tests
// ************************************************************
module tb;
  import iofs_pkg::*;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid, irq;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [1:0]  clock_mode_cfg = IOFS_INT_IO;
  logic        locked_source_cfg = 1'b1;
  logic        clock_in_gpio_o = 1'b1, clock_in_gpio_oe_n = 1'b0;
  logic        clock_out_gpio_o = 1'b1, clock_out_gpio_oe_n = 1'b1;
  logic        high_freq_internal_source, mid_freq_internal_source;
  logic        osc_locked_raw, osc_stable_raw, ext_clk;
  logic        clock_in_pin_i, clock_in_pin_o, clock_in_pin_oe_n;
  logic        clock_out_pin_i, clock_out_pin_o, clock_out_pin_oe_n;
  logic        sys_clk_o, int_clk_o, mon;
  logic [5:0]  osc_tuning_o;
  logic [1:0]  msel = 2'd0;
  int          errors = 0;
  int          samples_checked = 0;

  always #5 aclk = ~aclk;
  // external source lets go of the pin whenever the block drives it
  assign clock_in_pin_i  = clock_in_pin_oe_n ? ext_clk : clock_in_pin_o;
  assign clock_out_pin_i = clock_out_pin_oe_n ? 1'b1 : clock_out_pin_o;
  assign mon = msel == 2'd0 ? int_clk_o :
               msel == 2'd1 ? clock_out_pin_o : sys_clk_o;

  iofs_osc_model osc_u (.hf_src(high_freq_internal_source),
    .mf_src(mid_freq_internal_source), .ext_clk(ext_clk),
    .locked_raw(osc_locked_raw), .stable_raw(osc_stable_raw));
  iofs_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .clock_mode_cfg, .locked_source_cfg, .high_freq_internal_source,
    .mid_freq_internal_source, .osc_locked_raw, .osc_stable_raw,
    .clock_in_pin_i, .clock_in_gpio_o, .clock_in_gpio_oe_n, .clock_in_pin_o,
    .clock_in_pin_oe_n, .clock_out_pin_i, .clock_out_gpio_o,
    .clock_out_gpio_oe_n, .clock_out_pin_o, .clock_out_pin_oe_n, .sys_clk_o,
    .int_clk_o, .osc_tuning_o, .irq);

  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d, logic [1:0] er);
    logic aw_ok;
    logic w_ok;
    int   t;
    aw_ok = 1'b0;
    w_ok  = 1'b0;
    t     = 0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!(aw_ok && w_ok) && t < 50)
    begin
      @(posedge aclk);
      t++;
      aw_ok = aw_ok | s_axi_awready;
      w_ok  = w_ok | s_axi_wready;
      if (aw_ok)
        s_axi_awvalid <= 1'b0;
      if (w_ok)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && t < 50)
    begin
      @(posedge aclk);
      t++;
    end
    if (t >= 50)
      errors++;
    s_axi_bready <= 1'b0;
    chk("bresp", er, s_axi_bresp);
  endtask

  task automatic rd(logic [11:0] a, logic [31:0] e, logic [31:0] m,
                    logic [1:0] er);
    int t;
    t = 0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      t++;
    end while (s_axi_arready !== 1'b1 && t < 50);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1 && t < 50)
    begin
      @(posedge aclk);
      t++;
    end
    if (t >= 50)
      errors++;
    s_axi_rready <= 1'b0;
    chk("rdata", e, s_axi_rdata & m);
    chk("rresp", er, s_axi_rresp);
  endtask

  task automatic wl(logic v, inout int n);
    while (mon !== v && n < 3000)
    begin
      @(negedge aclk);
      n++;
    end
  endtask

  // last of three rise-to-rise spans, so a code change settles first
  task automatic per(logic [1:0] s, int e);
    int n;
    msel = s;
    repeat (3)
    begin
      n = 0;
      wl(1'b0, n);
      wl(1'b1, n);
    end
    chk("period", e, n);
  endtask

  task automatic rst();
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task automatic summarize();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #500_000;
    errors++;
    summarize();
  end

  initial
  begin
    rst();
    rd(IOFS_OSC_CONTROL_OFS, 32'h0000_0020, '1, AXI_OKAY);
    rd(IOFS_OSC_TUNING_OFS, 32'h0000_0000, '1, AXI_OKAY);
    repeat (120) @(posedge aclk);
    rd(IOFS_OSC_CONTROL_OFS, 32'h0000_0028, '1, AXI_OKAY);
    repeat (100) @(posedge aclk);
    rd(IOFS_OSC_CONTROL_OFS, 32'h0000_002c, '1, AXI_OKAY);
    wr(IOFS_OSC_CONTROL_OFS, 32'hffff_ffc3, AXI_OKAY);
    rd(IOFS_OSC_CONTROL_OFS, 32'h0000_000c, '1, AXI_OKAY);
    rd(IOFS_IRQ_STATUS_OFS, 32'h0000_0003, '1, AXI_OKAY);
    chk("irq", 1'b0, irq);
    wr(IOFS_IRQ_MASK_OFS, 32'h0000_0002, AXI_OKAY);
    repeat (3) @(posedge aclk);
    chk("irq", 1'b1, irq);
    wr(IOFS_IRQ_STATUS_OFS, 32'h0000_0003, AXI_OKAY);
    repeat (3) @(posedge aclk);
    chk("irq", 1'b0, irq);
    rd(IOFS_IRQ_STATUS_OFS, 32'h0000_0000, '1, AXI_OKAY);
    wr(12'h010, 32'h0000_0001, AXI_SLVERR);
    rd(12'h010, 32'h0000_0000, '1, AXI_SLVERR);
    wr(IOFS_OSC_TUNING_OFS, 32'hffff_ffe5, AXI_OKAY);
    rd(IOFS_OSC_TUNING_OFS, 32'h0000_0025, '1, AXI_OKAY);
    chk("tuning", 6'h25, osc_tuning_o);
    // lane 0 strobe low: write answered but ignored
    s_axi_wstrb <= 4'he;
    wr(IOFS_OSC_TUNING_OFS, 32'h0000_0011, AXI_OKAY);
    s_axi_wstrb <= 4'hf;
    rd(IOFS_OSC_TUNING_OFS, 32'h0000_0025, '1, AXI_OKAY);
    for (int s = 1; s >= 0; s--)
    begin
      @(posedge aclk);
      locked_source_cfg <= s[0];
      rst();
      chk("tuning", 6'h00, osc_tuning_o);
      rd(IOFS_OSC_CONTROL_OFS, 32'h0000_0020, 32'h0000_0030, AXI_OKAY);
      for (int c = 0; c < 4; c++)
      begin
        wr(IOFS_OSC_CONTROL_OFS, c << 4, AXI_OKAY);
        per(2'd0, (s ? 4 : 10) * (8 >> c));
      end
      wr(IOFS_OSC_CONTROL_OFS, 32'hffff_ffff, AXI_OKAY);
      per(2'd0, s ? 4 : 10);
    end
    for (int m = 0; m < 4; m++)
    begin
      @(posedge aclk);
      clock_mode_cfg <= m[1:0];
      repeat (3) @(posedge aclk);
      chk("in_oe_n", !m[1], clock_in_pin_oe_n);
      chk("in_pin", m[1], clock_in_pin_o);
      chk("out_oe_n", m[0], clock_out_pin_oe_n);
      per(2'd2, m[1] ? 10 : 6);
      if (!m[0])
        per(2'd1, m[1] ? 40 : 6);
      else
        chk("out_pin", 1'b1, clock_out_pin_o);
    end
    summarize();
  end
endmodule // tb
